// >>> src/adcp_pkg.sv
package adcp_pkg;

  // Clock rate and serial clock minimum periods per divider code
  localparam int ADCP_CLK_MHZ = 20;
  localparam int ADCP_SCLK_NS_0 = 25;
  localparam int ADCP_SCLK_NS_1 = 50;
  localparam int ADCP_SCLK_NS_2 = 100;
  localparam int ADCP_SCLK_NS_3 = 200;
  // Least periods round up to whole reference cycles
  localparam int ADCP_PER_0 = (ADCP_SCLK_NS_0 * ADCP_CLK_MHZ + 999) / 1000;
  localparam int ADCP_PER_1 = (ADCP_SCLK_NS_1 * ADCP_CLK_MHZ + 999) / 1000;
  localparam int ADCP_PER_2 = (ADCP_SCLK_NS_2 * ADCP_CLK_MHZ + 999) / 1000;
  localparam int ADCP_PER_3 = (ADCP_SCLK_NS_3 * ADCP_CLK_MHZ + 999) / 1000;
  // Half periods, never below one cycle
  localparam int ADCP_HALF_0 = (ADCP_PER_0 < 2) ? 1 : (ADCP_PER_0 + 1) / 2;
  localparam int ADCP_HALF_1 = (ADCP_PER_1 < 2) ? 1 : (ADCP_PER_1 + 1) / 2;
  localparam int ADCP_HALF_2 = (ADCP_PER_2 < 2) ? 1 : (ADCP_PER_2 + 1) / 2;
  localparam int ADCP_HALF_3 = (ADCP_PER_3 < 2) ? 1 : (ADCP_PER_3 + 1) / 2;
  localparam logic [4:0] ADCP_LAST_BIT = 5'h1F;

  // Synchroniser lanes
  localparam int ADCP_NSYNC = 11;
  localparam int ADCP_SY_PAIR = 0;
  localparam int ADCP_SY_SWAP = 1;
  localparam int ADCP_SY_CHAN = 2;
  localparam int ADCP_SY_LP = 3;
  localparam int ADCP_SY_SER = 4;
  localparam int ADCP_SY_DIV0 = 5;
  localparam int ADCP_SY_DIV1 = 6;
  localparam int ADCP_SY_EXT = 7;
  localparam int ADCP_SY_INV = 8;
  localparam int ADCP_SY_RDC = 9;
  localparam int ADCP_SY_SCLK = 10;

  // Data bus pin roles in serial mode
  localparam int ADCP_PIN_DIV0 = 2;
  localparam int ADCP_PIN_DIV1 = 3;
  localparam int ADCP_PIN_EXT = 4;
  localparam int ADCP_PIN_INV = 6;
  localparam int ADCP_PIN_RDC = 7;
  localparam int ADCP_PIN_SERIAL_RESULT_OUTPUT = 8;
  localparam int ADCP_PIN_SCLK = 9;

  // Register map, byte addresses
  localparam logic [7:0] ADCP_REG_CTRL = 8'h00;
  localparam logic [7:0] ADCP_REG_STATUS = 8'h04;
  localparam logic [7:0] ADCP_REG_RES_A = 8'h08;
  localparam logic [7:0] ADCP_REG_RES_B = 8'h0C;
  localparam int ADCP_CTRL_START = 0;
  localparam int ADCP_STAT_BUSY = 0;
  localparam int ADCP_STAT_SHIFT = 1;
  localparam int ADCP_STAT_VALID = 2;
  localparam int ADCP_STAT_SERIAL = 3;
  localparam int ADCP_STAT_SLAVE = 4;

  typedef enum logic [1:0] {
    ADCP_S_IDLE = 2'b01,
    ADCP_S_CONV = 2'b10
  } adcp_fsm_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } adcp_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } adcp_wb_rsp_t;

  typedef struct packed {
    logic done;
    logic [15:0] res_a;
    logic [15:0] res_b;
  } adcp_core_res_t;

  typedef struct packed {
    logic [ADCP_NSYNC-1:0] sync1;
    logic [ADCP_NSYNC-1:0] sync2;
    logic [ADCP_NSYNC-1:0] sync3;
    logic [ADCP_NSYNC-1:0] filt;
    adcp_fsm_t fsm;
    logic start;
    logic pair_sel;
    logic low_pwr;
    logic [15:0] res_a;
    logic [15:0] res_b;
    logic res_vld;
    logic [31:0] shreg;
    logic sh_act;
    logic [4:0] sh_cnt;
    logic [1:0] hc;
    logic sclk_raw;
    logic [15:0] d_out;
    logic [15:0] d_oe_n;
    logic ack;
    logic [31:0] dat;
  } adcp_state_t;

  localparam adcp_state_t ADCP_ST_RST = '{
    fsm: ADCP_S_IDLE, d_oe_n: 16'hFFFF, default: '0};

  // Half period of the internal serial clock for a divider code
  function automatic logic [1:0] adcp_half(input logic [1:0] code);
    case (code)
      2'h0: adcp_half = 2'(ADCP_HALF_0);
      2'h1: adcp_half = 2'(ADCP_HALF_1);
      2'h2: adcp_half = 2'(ADCP_HALF_2);
      default: adcp_half = 2'(ADCP_HALF_3);
    endcase
  endfunction

  // Serial word: selected channel first, MSB first
  function automatic logic [31:0] adcp_order(input logic [15:0] a,
                                             input logic [15:0] b,
                                             input logic a_first);
    adcp_order = a_first ? {a, b} : {b, a};
  endfunction

endpackage

// >>> src/adcp_top.sv
// Functional notes
// - Pair select low first pair, high second
// - Byte order select swaps result bytes in parallel mode
// - Parallel: channel select low B, high A
// - Serial: select high A first, else B
// - Low power select picks reduced power mode
// - Serial select low parallel, high serial port
// - Bus bits 0,1 high impedance in serial
// - Bus bits 2,3 become inputs in serial
// - Divider used only in master read-after-convert
// - Bus bit 4 becomes clock source input
// - Master mode drives internal serial clock out
// - Slave mode follows the external serial clock
// - Divider codes give 25/50/100/200 ns minimum
// - Read mode high shifts previous results early in master mode
// - 32-bit shift register, MSB first out
// - Slave output edge set by clock invert
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
module adcp_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register bus
  input wire adcp_pkg::adcp_wb_req_t wb_req,
  output adcp_pkg::adcp_wb_rsp_t wb_rsp,
  // Static mode selects
  input wire logic input_pair_select,
  input wire logic byte_order_select,
  input wire logic channel_select,
  input wire logic low_power_select,
  input wire logic serial_parallel_select,
  // Shared data bus pins
  input wire logic [15:0] d_in,
  output logic [15:0] d_out,
  output logic [15:0] d_oe_n,
  // Converter core
  output logic conv_start,
  output logic conv_pair_sel,
  output logic conv_low_power,
  input wire adcp_pkg::adcp_core_res_t core_res
);
  import adcp_pkg::*;

  adcp_state_t st_r;
  adcp_state_t st_nxt;
  logic [ADCP_NSYNC-1:0] pins_sync;

  // Inputs from outside the clock domain
  assign pins_sync = {d_in[ADCP_PIN_SCLK], d_in[ADCP_PIN_RDC],
                      d_in[ADCP_PIN_INV], d_in[ADCP_PIN_EXT],
                      d_in[ADCP_PIN_DIV1], d_in[ADCP_PIN_DIV0],
                      serial_parallel_select, low_power_select,
                      channel_select, byte_order_select,
                      input_pair_select};

  // Next state
  always_comb begin
    logic ser;
    logic master;
    logic rdc;
    logic inv;
    logic act_edge;
    logic start_req;
    logic load_prev;
    logic load_new;
    logic [1:0] half;
    logic [15:0] word;
    ser = 1'b0;
    master = 1'b0;
    rdc = 1'b0;
    inv = 1'b0;
    act_edge = 1'b0;
    start_req = 1'b0;
    load_prev = 1'b0;
    load_new = 1'b0;
    half = 2'h0;
    word = 16'h0000;
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.ack = 1'b0;
    // Three-stage synchronisers, change taken when stages 2 and 3 agree
    st_nxt.sync1 = pins_sync;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    for (int i = 0; i < ADCP_NSYNC; i++) begin
      if (st_r.sync2[i] == st_r.sync3[i]) begin
        st_nxt.filt[i] = st_r.sync3[i];
      end
    end
    // Mode decode
    ser = st_r.filt[ADCP_SY_SER];
    master = ~st_r.filt[ADCP_SY_EXT];
    rdc = st_r.filt[ADCP_SY_RDC];
    inv = st_r.filt[ADCP_SY_INV];
    // Divider only honoured in master read-after-convert
    if (master && !rdc) begin
      half = adcp_half({st_r.filt[ADCP_SY_DIV1],
                        st_r.filt[ADCP_SY_DIV0]});
    end else begin
      half = adcp_half(2'h0);
    end
    // Active external clock edge: rising, or falling when inverted
    act_edge = ser && !master && st_r.sh_act &&
               (st_nxt.filt[ADCP_SY_SCLK] != st_r.filt[ADCP_SY_SCLK]) &&
               (st_nxt.filt[ADCP_SY_SCLK] == ~inv);
    // Wishbone slave, one wait state, unmapped reads give zero
    if (wb_req.cyc && wb_req.stb && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.dat = 32'h0000_0000;
      case (wb_req.adr)
        ADCP_REG_STATUS: begin
          st_nxt.dat[ADCP_STAT_BUSY] = (st_r.fsm == ADCP_S_CONV);
          st_nxt.dat[ADCP_STAT_SHIFT] = st_r.sh_act;
          st_nxt.dat[ADCP_STAT_VALID] = st_r.res_vld;
          st_nxt.dat[ADCP_STAT_SERIAL] = ser;
          st_nxt.dat[ADCP_STAT_SLAVE] = ~master;
        end
        ADCP_REG_RES_A: st_nxt.dat = {16'h0000, st_r.res_a};
        ADCP_REG_RES_B: st_nxt.dat = {16'h0000, st_r.res_b};
        default: st_nxt.dat = 32'h0000_0000;
      endcase
      if (wb_req.we && wb_req.adr == ADCP_REG_CTRL && wb_req.sel[0]) begin
        start_req = wb_req.dat[ADCP_CTRL_START];
      end
    end
    // Conversion sequence
    case (st_r.fsm)
      ADCP_S_IDLE: begin
        if (start_req) begin
          st_nxt.fsm = ADCP_S_CONV;
          st_nxt.start = 1'b1;
          st_nxt.pair_sel = st_r.filt[ADCP_SY_PAIR];
          st_nxt.low_pwr = st_r.filt[ADCP_SY_LP];
          load_prev = ser && master && rdc;
        end
      end
      ADCP_S_CONV: begin
        if (core_res.done) begin
          st_nxt.fsm = ADCP_S_IDLE;
          st_nxt.res_a = core_res.res_a;
          st_nxt.res_b = core_res.res_b;
          st_nxt.res_vld = 1'b1;
          load_new = ser && !(master && rdc);
        end
      end
      default: st_nxt.fsm = ADCP_S_IDLE;
    endcase
    // Serial shift register load and shifting
    if (load_prev || load_new) begin
      st_nxt.shreg = load_prev ?
        adcp_order(st_r.res_a, st_r.res_b, st_r.filt[ADCP_SY_CHAN]) :
        adcp_order(core_res.res_a, core_res.res_b,
                   st_r.filt[ADCP_SY_CHAN]);
      st_nxt.sh_act = 1'b1;
      st_nxt.sh_cnt = 5'h00;
      st_nxt.hc = 2'h0;
      st_nxt.sclk_raw = 1'b0;
    end else if (st_r.sh_act && master) begin
      // Internal clock: data advances on each falling phase
      if (st_r.hc == half - 2'h1) begin
        st_nxt.hc = 2'h0;
        st_nxt.sclk_raw = ~st_r.sclk_raw;
        if (st_r.sclk_raw) begin
          st_nxt.shreg = {st_r.shreg[30:0], 1'b0};
          if (st_r.sh_cnt == ADCP_LAST_BIT) begin
            st_nxt.sh_act = 1'b0;
          end else begin
            st_nxt.sh_cnt = st_r.sh_cnt + 5'h01;
          end
        end
      end else begin
        st_nxt.hc = st_r.hc + 2'h1;
      end
    end else if (act_edge) begin
      // External clock: chain input fills from the bottom
      st_nxt.shreg = {st_r.shreg[30:0], rdc};
      if (st_r.sh_cnt == ADCP_LAST_BIT) begin
        st_nxt.sh_act = 1'b0;
      end else begin
        st_nxt.sh_cnt = st_r.sh_cnt + 5'h01;
      end
    end
    // Data bus pins
    if (!ser) begin
      word = st_r.filt[ADCP_SY_CHAN] ? st_r.res_a : st_r.res_b;
      st_nxt.d_out = st_r.filt[ADCP_SY_SWAP] ?
                     {word[7:0], word[15:8]} : word;
      st_nxt.d_oe_n = 16'h0000;
    end else begin
      st_nxt.d_oe_n = 16'hFFFF;
      st_nxt.d_out = 16'h0000;
      st_nxt.d_oe_n[ADCP_PIN_SERIAL_RESULT_OUTPUT] = 1'b0;
      st_nxt.d_out[ADCP_PIN_SERIAL_RESULT_OUTPUT] = st_r.shreg[31];
      if (master) begin
        st_nxt.d_oe_n[ADCP_PIN_SCLK] = 1'b0;
        st_nxt.d_out[ADCP_PIN_SCLK] = st_r.sclk_raw ^ inv;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ADCP_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs, all from flip-flops
  assign wb_rsp = '{ack: st_r.ack, dat: st_r.dat};
  assign d_out = st_r.d_out;
  assign d_oe_n = st_r.d_oe_n;
  assign conv_start = st_r.start;
  assign conv_pair_sel = st_r.pair_sel;
  assign conv_low_power = st_r.low_pwr;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_pair_latch: assert property (
    st_r.start |-> st_r.pair_sel == $past(st_r.filt[ADCP_SY_PAIR]))
    else $error("pair select not taken at start");
  a_byte_swap: assert property (
    (!st_r.filt[ADCP_SY_SER] && st_r.filt[ADCP_SY_SWAP] &&
     st_r.filt[ADCP_SY_CHAN]) |=> st_r.d_out[7:0] == $past(st_r.res_a[15:8]))
    else $error("swapped byte lane wrong");
  a_chan_b_par: assert property (
    (!st_r.filt[ADCP_SY_SER] && !st_r.filt[ADCP_SY_SWAP] &&
     !st_r.filt[ADCP_SY_CHAN]) |=> st_r.d_out == $past(st_r.res_b))
    else $error("parallel word not channel B");
  a_ser_order: assert property (
    ($rose(st_r.sh_act) && $past(st_r.filt[ADCP_SY_CHAN]))
      |-> st_r.shreg[31:16] == st_r.res_a)
    else $error("channel A not first");
  a_low_power: assert property (
    st_r.start |-> st_r.low_pwr == $past(st_r.filt[ADCP_SY_LP]))
    else $error("low power select not taken");
  a_par_drive: assert property (
    !st_r.filt[ADCP_SY_SER] |=> st_r.d_oe_n == 16'h0000)
    else $error("parallel bus not driven");
  a_low_bits_hiz: assert property (
    st_r.filt[ADCP_SY_SER] |=> st_r.d_oe_n[1:0] == 2'h3)
    else $error("bits 0 and 1 driven in serial");
  a_div_pins_in: assert property (
    st_r.filt[ADCP_SY_SER] |=> st_r.d_oe_n[3:2] == 2'h3)
    else $error("bits 2 and 3 driven in serial");
  a_div_ignored: assert property (
    (st_r.sh_act && !st_r.filt[ADCP_SY_EXT] && st_r.filt[ADCP_SY_RDC] &&
     $rose(st_r.sclk_raw)) |=> $fell(st_r.sclk_raw))
    else $error("divider used outside read after convert");
  a_ext_pin_in: assert property (
    st_r.filt[ADCP_SY_SER] |=> st_r.d_oe_n[ADCP_PIN_EXT])
    else $error("clock source pin driven in serial");
  a_master_sclk: assert property (
    (st_r.filt[ADCP_SY_SER] && !st_r.filt[ADCP_SY_EXT])
      |=> !st_r.d_oe_n[ADCP_PIN_SCLK])
    else $error("master serial clock not driven");
  a_slave_sclk: assert property (
    (st_r.filt[ADCP_SY_SER] && st_r.filt[ADCP_SY_EXT])
      |=> st_r.d_oe_n[ADCP_PIN_SCLK])
    else $error("slave serial clock pin driven");
  a_div_slowest: assert property (
    (st_r.sh_act && !st_r.filt[ADCP_SY_EXT] && !st_r.filt[ADCP_SY_RDC] &&
     st_r.filt[ADCP_SY_DIV1] && st_r.filt[ADCP_SY_DIV0] &&
     $changed(st_r.sclk_raw)) |=> $stable(st_r.sclk_raw))
    else $error("slowest serial clock phase too short");
  a_read_during: assert property (
    (st_r.start && $past(st_r.filt[ADCP_SY_SER]) &&
     !$past(st_r.filt[ADCP_SY_EXT]) && $past(st_r.filt[ADCP_SY_RDC]))
      |-> st_r.sh_act)
    else $error("previous result not shifted during conversion");
  a_shift_count: assert property (
    $fell(st_r.sh_act) |-> $past(st_r.sh_cnt) == ADCP_LAST_BIT)
    else $error("serial word not 32 bits");
  a_slave_edge: assert property (
    ($past(st_r.filt[ADCP_SY_SER]) && $past(st_r.filt[ADCP_SY_EXT]) &&
     $past(st_r.sh_act) && $past(st_r.fsm) == ADCP_S_IDLE &&
     $changed(st_r.shreg))
      |-> ($changed(st_r.filt[ADCP_SY_SCLK]) &&
           st_r.filt[ADCP_SY_SCLK] != $past(st_r.filt[ADCP_SY_INV])))
    else $error("slave shift on wrong clock edge");
  a_chan_a_par: assert property (
    (!st_r.filt[ADCP_SY_SER] && !st_r.filt[ADCP_SY_SWAP] &&
     st_r.filt[ADCP_SY_CHAN]) |=> st_r.d_out == $past(st_r.res_a))
    else $error("parallel word not channel A");
  a_swap_high: assert property (
    (!st_r.filt[ADCP_SY_SER] && st_r.filt[ADCP_SY_SWAP] &&
     !st_r.filt[ADCP_SY_CHAN])
      |=> st_r.d_out[15:8] == $past(st_r.res_b[7:0]))
    else $error("swapped upper byte lane wrong");
  a_ser_b_first: assert property (
    ($rose(st_r.sh_act) && !$past(st_r.filt[ADCP_SY_CHAN]))
      |-> st_r.shreg[31:16] == st_r.res_b)
    else $error("channel B not first");
  a_serial_result_output_msb: assert property (
    st_r.filt[ADCP_SY_SER]
      |=> st_r.d_out[ADCP_PIN_SERIAL_RESULT_OUTPUT] == $past(st_r.shreg[31]))
    else $error("serial output not shift register top bit");
  a_master_clk_out: assert property (
    (st_r.filt[ADCP_SY_SER] && !st_r.filt[ADCP_SY_EXT])
      |=> st_r.d_out[ADCP_PIN_SCLK] ==
          ($past(st_r.sclk_raw) ^ $past(st_r.filt[ADCP_SY_INV])))
    else $error("master serial clock level wrong");
  a_ack_pulse: assert property (
    st_r.ack |=> !st_r.ack)
    else $error("bus acknowledge longer than one cycle");

endmodule // adcp_top

// >>> sim/adcp_host_model.sv
`timescale 1ns/10ps
module adcp_host_model (
  // Clock and control
  input wire logic ref_clk,
  input wire logic slave,
  input wire logic go,
  input wire logic clr,
  // Serial port pins
  input wire logic sclk_in,
  input wire logic sdo,
  output logic ext_sclk,
  // Captured frame
  output logic [31:0] word,
  output int nbits,
  output int per
);
  logic last;
  logic run;
  int since;
  int ph;

  // Power-up state of the reader
  initial begin
    ext_sclk = 1'b0;
    word = 32'h0;
    nbits = 0;
    per = 0;
    last = 1'b0;
    run = 1'b0;
    since = 0;
    ph = 0;
  end

  // Master: sample on rising clock; slave: make 32 slow clocks
  always @(posedge ref_clk) begin
    last <= sclk_in;
    since <= since + 1;
    if (clr) begin
      nbits <= 0;
      word <= 32'h0;
      run <= 1'b0;
      ph <= 0;
    end else if (slave) begin
      if (go) begin
        run <= 1'b1;
      end
      // Clock stands low outside the frame, 6 cycles per half
      if (run) begin
        ph <= (ph == 11) ? 0 : ph + 1;
        if (ph == 5) begin
          word <= {word[30:0], sdo};
          nbits <= nbits + 1;
          ext_sclk <= 1'b1;
        end
        if (ph == 11) begin
          ext_sclk <= 1'b0;
          if (nbits == 32) begin
            run <= 1'b0;
          end
        end
      end
    end else if (sclk_in && !last) begin
      word <= {word[30:0], sdo};
      nbits <= nbits + 1;
      per <= since;
      since <= 1;
    end
  end
endmodule // adcp_host_model

// >>> sim/adcp_top_tb_top.sv
`timescale 1ns/10ps
module adcp_top_tb_top;
  import adcp_pkg::*;
  logic ref_clk, sys_rst, pair, swap, chan, lp, sp, hclr, hgo;
  logic conv_start, conv_pair_sel, conv_low_power, ext_sclk;
  logic [15:0] pins, d_out, d_oe_n, d_in, pa, pb;
  logic [31:0] q, word;
  logic [7:0] k;
  adcp_wb_req_t req;
  adcp_wb_rsp_t rsp;
  adcp_core_res_t core;
  int nbits, per, errors, n_compared, cnt, nst;

  // Wire level of each shared pin
  assign d_in = (d_oe_n & {pins[15:10], ext_sclk, pins[8:0]}) |
                (~d_oe_n & d_out);

  adcp_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_req(req),
    .wb_rsp(rsp), .input_pair_select(pair), .byte_order_select(swap),
    .channel_select(chan), .low_power_select(lp),
    .serial_parallel_select(sp), .d_in(d_in), .d_out(d_out),
    .d_oe_n(d_oe_n), .conv_start(conv_start),
    .conv_pair_sel(conv_pair_sel), .conv_low_power(conv_low_power),
    .core_res(core));
  adcp_host_model host (.ref_clk(ref_clk), .slave(pins[4]), .go(hgo),
    .clr(hclr), .sclk_in(d_out[9]), .sdo(d_out[8]), .ext_sclk(ext_sclk),
    .word(word), .nbits(nbits), .per(per));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Converter core stand-in: results 100 cycles after start
  always @(posedge ref_clk) begin
    core.done <= (cnt == 1) && !conv_start;
    if (conv_start) begin
      cnt <= 100;
      k <= k + 8'h01;
      nst <= nst + 1;
    end else if (cnt == 1) begin
      core.res_a <= {7'h50, conv_pair_sel, k};
      core.res_b <= {8'hC3, ~k};
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic Wishbone cycle, answer left in q
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
    @(posedge ref_clk);
  endtask

  task wait_idle;
    do begin
      wb(1'b0, ADCP_REG_STATUS, 32'h0);
    end while (q[ADCP_STAT_BUSY] !== 1'b0);
  endtask

  task wait_bits;
    int n;
    n = 0;
    while (nbits != 32 && n < 800) begin
      @(posedge ref_clk);
      n++;
    end
    chk("bit count", 32'd32, nbits);
  endtask

  // Mode pins change only between conversions
  task mode(input logic p, s, c, l, m, input logic [15:0] pn);
    pair <= p;
    swap <= s;
    chan <= c;
    lp <= l;
    sp <= m;
    pins <= pn;
    // Serial pin roles need a second pass through the synchronisers
    repeat (12) @(posedge ref_clk);
  endtask

  task par_view(input logic s, c);
    logic [15:0] v;
    mode(pair, s, c, lp, 1'b0, 16'h0);
    v = c ? core.res_a : core.res_b;
    chk("parallel bus", {16'h0, s ? {v[7:0], v[15:8]} : v},
        {16'h0, d_out});
    chk("parallel enables", 32'h0, {16'h0, d_oe_n});
  endtask

  task results;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    results();
  end

  initial begin
    {sys_rst, hclr, pair, swap, chan, lp, sp, hgo} = 8'h C0;
    {req, core, pins, k, cnt} = '0;
    {errors, n_compared, nst} = '0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Parallel conversion, first pair, full power
    mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0);
    wb(1'b1, ADCP_REG_CTRL, 32'h1);
    chk("pair select", 32'h0, {31'h0, conv_pair_sel});
    chk("low power", 32'h0, {31'h0, conv_low_power});
    // Start while busy must be ignored
    wb(1'b1, ADCP_REG_CTRL, 32'h1);
    wait_idle();
    wb(1'b0, ADCP_REG_RES_A, 32'h0);
    chk("result A", {16'h0, core.res_a}, q);
    wb(1'b0, ADCP_REG_RES_B, 32'h0);
    chk("result B", {16'h0, core.res_b}, q);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, q);
    for (int i = 0; i < 4; i++) par_view(i[1], i[0]);
    $display("Test parallel first pair done");
    // Second pair in reduced power mode
    mode(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0);
    wb(1'b1, ADCP_REG_CTRL, 32'h1);
    chk("pair select", 32'h1, {31'h0, conv_pair_sel});
    chk("low power", 32'h1, {31'h0, conv_low_power});
    wait_idle();
    par_view(1'b0, 1'b1);
    $display("Test second pair done");
    // Master read after convert, slowest divider, A first
    mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 16'h000C);
    hclr <= 1'b0;
    chk("master enables", 32'hFCFF, {16'h0, d_oe_n});
    wb(1'b1, ADCP_REG_CTRL, 32'h1);
    wait_idle();
    wait_bits();
    chk("master word", {core.res_a, core.res_b}, word);
    chk("master period", 32'd4, per);
    wb(1'b0, ADCP_REG_STATUS, 32'h0);
    chk("master status", 32'h08, q & 32'h18);
    $display("Test master after convert done");
    // Read during convert: previous data, divider ignored, B first
    pa = core.res_a;
    pb = core.res_b;
    hclr <= 1'b1;
    mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h008C);
    hclr <= 1'b0;
    wb(1'b1, ADCP_REG_CTRL, 32'h1);
    wait_bits();
    chk("during convert word", {pb, pa}, word);
    chk("undivided period", 32'd2, per);
    wait_idle();
    $display("Test master during convert done");
    // Slave mode, clock from the host, B first
    hclr <= 1'b1;
    mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0010);
    hclr <= 1'b0;
    chk("slave enables", 32'hFEFF, {16'h0, d_oe_n});
    wb(1'b1, ADCP_REG_CTRL, 32'h1);
    wait_idle();
    hgo <= 1'b1;
    @(posedge ref_clk);
    hgo <= 1'b0;
    wait_bits();
    chk("slave word", {core.res_b, core.res_a}, word);
    wb(1'b0, ADCP_REG_STATUS, 32'h0);
    chk("slave status", 32'h18, q & 32'h18);
    $display("Test slave done");
    chk("start pulses", 32'd5, nst);
    results();
  end
endmodule // adcp_top_tb_top
